// ==== spnf_feature_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "spnf_consts.vh"
module spnf_feature_regs (
	input  wire       clk,
	input  wire       rst,
	// serial pins, asynchronous to clk
	input  wire       sck,
	input  wire       cs_n,
	input  wire       mosi,
	output reg        miso,
	output wire       miso_oe,
	// array engine side
	input  wire       array_req,
	input  wire [1:0] array_kind,
	input  wire [9:0] array_block,
	input  wire       array_addr_bad,
	input  wire       array_otp,
	output wire       array_grant,
	input  wire       array_busy,
	input  wire       array_done,
	input  wire       array_fail,
	input  wire [1:0] array_ecc,
	output reg        reset_cmd,
	// settings seen by the array engine
	output wire       ecc_enable,
	output wire [1:0] otp_mode,
	output wire       otp_access,
	output wire       hw_guard_pin_on
);
	localparam [2:0] ST_CMD   = 3'h0;
	localparam [2:0] ST_ADDR  = 3'h1;
	localparam [2:0] ST_WDATA = 3'h2;
	localparam [2:0] ST_RDATA = 3'h3;
	localparam [2:0] ST_SKIP  = 3'h4;

	// three-stage pin synchronisers
	wire [2:0] pin_raw;
	wire [2:0] pin_f;
	assign pin_raw = {sck, cs_n, mosi};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg f_q;
			always @(posedge clk) begin
				if (rst) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					f_q  <= (gi == 1) ? 1'b1 : 1'b0;
				end else begin
					s1_q <= pin_raw[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					// only accept a level once two stages agree
					if (s2_q == s3_q) begin
						f_q <= s3_q;
					end
				end
			end
			assign pin_f[gi] = f_q;
		end
	endgenerate

	wire sck_f;
	wire cs_n_f;
	wire mosi_f;
	assign sck_f  = pin_f[2];
	assign cs_n_f = pin_f[1];
	assign mosi_f = pin_f[0];

	reg sck_prev_q;
	always @(posedge clk) begin
		if (rst) begin
			sck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_f;
		end
	end
	wire sck_rise;
	wire sck_fall;
	assign sck_rise = sck_f & ~sck_prev_q & ~cs_n_f;
	assign sck_fall = ~sck_f & sck_prev_q & ~cs_n_f;

	// register state
	reg [7:0] protection_settings_q;
	reg       otp_lock_q;
	reg       otp_en_q;
	reg       protection_freeze_q;
	reg       ecc_en_q;
	reg       write_permit_latch_q;
	reg       prog_fail_q;
	reg       erase_fail_q;
	reg [1:0] ecc_result_q;

	wire [7:0] configuration_control;
	wire [7:0] operation_status;
	assign configuration_control = {otp_lock_q, otp_en_q, protection_freeze_q, ecc_en_q,
		4'h0}; // [R23]
	assign operation_status = {2'h0, ecc_result_q, prog_fail_q, erase_fail_q,
		write_permit_latch_q, array_busy}; // [R15] [R23]

	function [7:0] reg_view;
		input [7:0] addr;
		input [7:0] prot;
		input [7:0] cfg;
		input [7:0] stat;
		begin
			case (addr)
				`SPNF_ADDR_PROT: reg_view = prot;
				`SPNF_ADDR_CFG:  reg_view = cfg;
				`SPNF_ADDR_STAT: reg_view = stat; // [R9]
				default:         reg_view = 8'h00;
			endcase
		end
	endfunction

	// serial command engine
	reg [2:0] state_q;
	reg [2:0] bit_cnt_q;
	reg [7:0] shift_in_q;
	reg [7:0] cmd_q;
	reg [7:0] addr_q;
	reg [7:0] shift_out_q;
	reg       out_live_q;

	wire [7:0] byte_in;
	wire       byte_done;
	assign byte_in   = {shift_in_q[6:0], mosi_f};
	assign byte_done = sck_rise & (bit_cnt_q == 3'h7);

	reg cmd_write_on;
	reg cmd_write_off;
	reg wr_prot;
	reg wr_cfg;
	always @* begin
		cmd_write_on  = 1'b0;
		cmd_write_off = 1'b0;
		wr_prot       = 1'b0;
		wr_cfg        = 1'b0;
		if (byte_done && state_q == ST_CMD) begin
			cmd_write_on  = (byte_in == `SPNF_CMD_WRITE_ON); // [R22]
			cmd_write_off = (byte_in == `SPNF_CMD_WRITE_OFF); // [R22]
		end
		if (byte_done && state_q == ST_WDATA) begin
			wr_prot = (addr_q == `SPNF_ADDR_PROT);
			wr_cfg  = (addr_q == `SPNF_ADDR_CFG);
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			state_q     <= ST_CMD;
			bit_cnt_q   <= 3'h0;
			shift_in_q  <= 8'h00;
			cmd_q       <= 8'h00;
			addr_q      <= 8'h00;
			shift_out_q <= 8'h00;
			out_live_q  <= 1'b0;
			miso        <= 1'b0;
			reset_cmd   <= 1'b0;
		end else begin
			reset_cmd <= 1'b0;
			if (cs_n_f) begin
				// frame ends with chip select, whatever the byte count
				state_q    <= ST_CMD;
				bit_cnt_q  <= 3'h0;
				out_live_q <= 1'b0;
			end else begin
				if (sck_rise) begin
					shift_in_q <= byte_in;
					bit_cnt_q  <= bit_cnt_q + 3'h1;
				end
				if (byte_done) begin
					case (state_q)
						ST_CMD: begin
							cmd_q <= byte_in;
							if (byte_in == `SPNF_CMD_READ_REG ||
								byte_in == `SPNF_CMD_WRITE_REG) begin
								state_q <= ST_ADDR; // [R20]
							end else begin
								state_q <= ST_SKIP;
							end
							reset_cmd <= (byte_in == `SPNF_CMD_RESET);
						end
						ST_ADDR: begin
							addr_q <= byte_in;
							if (cmd_q == `SPNF_CMD_READ_REG) begin
								state_q     <= ST_RDATA;
								shift_out_q <= reg_view(byte_in, protection_settings_q,
									configuration_control, operation_status); // [R9]
								out_live_q  <= 1'b1;
							end else begin
								state_q <= ST_WDATA;
							end
						end
						ST_WDATA: begin
							state_q <= ST_SKIP;
						end
						ST_RDATA: begin
							// keep repeating the register so busy can be watched
							shift_out_q <= reg_view(addr_q, protection_settings_q,
								configuration_control, operation_status);
						end
						ST_SKIP: begin
							state_q <= ST_SKIP;
						end
						default: begin
							state_q <= ST_SKIP;
						end
					endcase
				end else if (sck_fall && out_live_q) begin
					// output changes on the synchronised falling edge, host samples late in the high phase, just before the next fall
					miso        <= shift_out_q[7];
					shift_out_q <= {shift_out_q[6:0], 1'b0};
				end
			end
		end
	end
	assign miso_oe = out_live_q & ~cs_n_f;

	// protection and configuration writes
	always @(posedge clk) begin
		if (rst) begin
			protection_settings_q <= `SPNF_PROT_RESET;
			otp_lock_q            <= 1'b0;
			otp_en_q              <= 1'b0;
			protection_freeze_q   <= 1'b0;
			ecc_en_q              <= 1'b1; // [R4]
		end else begin
			if (wr_prot && !protection_freeze_q) begin
				protection_settings_q <= byte_in; // [R21] [R7]
			end
			if (wr_cfg) begin
				otp_en_q <= byte_in[`SPNF_CFG_OTP_EN]; // [R8]
				ecc_en_q <= byte_in[`SPNF_CFG_ECC_EN]; // [R8] [R4]
				// otp lock only sticks together with enable, and clears only on rst
				if (byte_in[`SPNF_CFG_OTP_LOCK] && byte_in[`SPNF_CFG_OTP_EN]) begin
					otp_lock_q <= 1'b1; // [R6]
				end
				if (byte_in[`SPNF_CFG_FREEZE] &&
					protection_settings_q[`SPNF_PROT_GUARD_HI] &&
					protection_settings_q[`SPNF_PROT_GUARD_LO]) begin
					protection_freeze_q <= 1'b1; // [R7]
				end
			end
		end
	end

	assign ecc_enable      = ecc_en_q; // [R4]
	assign otp_mode        = {otp_lock_q, otp_en_q}; // [R6]
	assign otp_access      = otp_en_q; // [R5]
	assign hw_guard_pin_on = protection_settings_q[`SPNF_PROT_HW_GUARD];

	// array request admission
	wire target_locked;
	spnf_lock_decode u_lock (
		.region_lock_code  (protection_settings_q[`SPNF_PROT_CODE_MSB:`SPNF_PROT_CODE_LSB]),
		.lock_from_low_end (protection_settings_q[`SPNF_PROT_LOW_END]),
		.block             (array_block),
		.locked            (target_locked)
	);

	wire is_prog;
	wire is_erase;
	wire is_read;
	wire otp_ok;
	wire prog_refused;
	wire erase_refused;
	assign is_prog  = array_req & (array_kind == `SPNF_KIND_PROGRAM);
	assign is_erase = array_req & (array_kind == `SPNF_KIND_ERASE);
	assign is_read  = array_req & (array_kind == `SPNF_KIND_READ);
	// otp space reachable only with enable set; programming it also needs it unlocked
	assign otp_ok = ~array_otp | (otp_en_q & ~(is_prog & otp_lock_q)); // [R5] [R6]
	assign prog_refused  = array_addr_bad | (~array_otp & target_locked); // [R3] [R10]
	assign erase_refused = array_addr_bad | target_locked; // [R3] [R12]
	assign array_grant = otp_ok & ~array_busy & (is_read |
		(is_prog & write_permit_latch_q & ~prog_refused) |
		(is_erase & write_permit_latch_q & ~erase_refused)); // [R14] [R3]

	// pending operation kind, so completion goes to the right flag
	reg [1:0] run_kind_q;
	always @(posedge clk) begin
		if (rst) begin
			run_kind_q <= `SPNF_KIND_READ; // power-up page load counts as a read
		end else if (array_grant) begin
			run_kind_q <= array_kind;
		end
	end

	// status flags: a setting event beats a clearing one in the same cycle
	always @(posedge clk) begin
		if (rst) begin
			write_permit_latch_q <= 1'b0;
			prog_fail_q          <= 1'b0;
			erase_fail_q         <= 1'b0;
			ecc_result_q         <= 2'h0; // [R16]
		end else begin
			if (cmd_write_on) begin
				write_permit_latch_q <= 1'b1; // [R14] [R22]
			end else if (cmd_write_off) begin
				write_permit_latch_q <= 1'b0; // [R14] [R22]
			end
			if (array_done && run_kind_q == `SPNF_KIND_PROGRAM && array_fail) begin
				prog_fail_q <= 1'b1; // [R10]
			end else if (is_prog && prog_refused && write_permit_latch_q) begin
				prog_fail_q <= 1'b1; // [R10]
			end else if (is_prog || reset_cmd) begin
				prog_fail_q <= 1'b0; // [R11]
			end
			if (array_done && run_kind_q == `SPNF_KIND_ERASE && array_fail) begin
				erase_fail_q <= 1'b1; // [R12]
			end else if (is_erase && erase_refused && write_permit_latch_q) begin
				erase_fail_q <= 1'b1; // [R12]
			end else if (is_erase || reset_cmd) begin
				erase_fail_q <= 1'b0; // [R13]
			end
			if (array_done && run_kind_q == `SPNF_KIND_READ) begin
				ecc_result_q <= array_ecc; // [R16] [R18] [R19]
			end else if ((is_read && array_grant) || reset_cmd) begin
				ecc_result_q <= 2'h0; // [R16]
			end
		end
	end
endmodule // spnf_feature_regs
`default_nettype wire

// ==== spnf_consts.vh ====
// What this block does
// R1: top/bottom 0: codes 1..9 lock upper 1/512 doubling to 1/2; 0 none, >=10 all
// R2: top/bottom 1: same codes lock from block 0 upward, smallest blocks 0 and 1
// R3: erase or program aimed inside the locked region is refused, array untouched
// R4: ecc enable bit switches internal correction for reads and programs, reset value 1
// R5: otp, unique id and parameter page access only while otp enable is 1
// R6: otp lock/enable: 00 normal, 01 otp space, 11 otp locked for good, 10 unused
// R7: host sets guards both 1 before freeze; freeze holds protection until power cycle
// R8: configuration bits 6 and 4 are plain volatile writable settings
// R9: status may be polled any time with read command then address c0
// R10: program fail sets on failed program, invalid address or locked target
// R11: program fail clears at start of program and on reset command
// R12: erase fail sets on failed erase or attempt to erase a locked region
// R13: erase fail clears at start of block erase and on reset command
// R14: write permit latch set by 06, cleared by 04, needed for program and erase
// R15: busy flag is 1 while program, page read, erase or reset executes
// R16: ecc result clears on reset and at read start, updates at read completion
// R17: host ignores ecc result while internal ecc is disabled
// R18: after power-up the ecc result reflects the automatic first page load
// R19: ecc result codes: 00 clean, 01 one corrected, 10 uncorrectable, 11 reserved
// R20: read with 0f, write with 1f plus one address byte; values survive reset command
// R21: protection register at a0: lock code bits 6..3, low-end select bit 2, all writable
// R22: command 06 sets write permit latch, 04 clears it
// R23: reserved configuration and status bits read zero, writes ignored
`ifndef SPNF_CONSTS_VH
`define SPNF_CONSTS_VH
`define SPNF_CMD_READ_REG     8'h0f
`define SPNF_CMD_WRITE_REG    8'h1f
`define SPNF_CMD_WRITE_ON     8'h06
`define SPNF_CMD_WRITE_OFF    8'h04
`define SPNF_CMD_RESET        8'hff
`define SPNF_ADDR_PROT        8'ha0
`define SPNF_ADDR_CFG         8'hb0
`define SPNF_ADDR_STAT        8'hc0
`define SPNF_PROT_RESET       8'h7c
`define SPNF_CFG_RESET        8'h10
`define SPNF_PROT_GUARD_HI    7
`define SPNF_PROT_CODE_MSB    6
`define SPNF_PROT_CODE_LSB    3
`define SPNF_PROT_LOW_END     2
`define SPNF_PROT_HW_GUARD    1
`define SPNF_PROT_GUARD_LO    0
`define SPNF_CFG_OTP_LOCK     7
`define SPNF_CFG_OTP_EN       6
`define SPNF_CFG_FREEZE       5
`define SPNF_CFG_ECC_EN       4
`define SPNF_KIND_READ        2'h0
`define SPNF_KIND_PROGRAM     2'h1
`define SPNF_KIND_ERASE       2'h2
`define SPNF_BLOCKS           11'h400
`define SPNF_CODE_ALL         4'ha
`endif

// ==== spnf_lock_decode.v ====
`timescale 1ns/1ps
`default_nettype none
`include "spnf_consts.vh"
module spnf_lock_decode (
	input  wire [3:0] region_lock_code,
	input  wire       lock_from_low_end,
	input  wire [9:0] block,
	output reg        locked
);
	reg [10:0] span;
	always @* begin
		span = 11'h002 << (region_lock_code - 4'h1);
		if (region_lock_code == 4'h0) begin
			locked = 1'b0;
		end else if (region_lock_code >= `SPNF_CODE_ALL) begin
			locked = 1'b1;
		end else if (lock_from_low_end) begin
			locked = ({1'b0, block} < span); // [R2]
		end else begin
			locked = ({1'b0, block} >= (`SPNF_BLOCKS - span)); // [R1]
		end
	end
endmodule // spnf_lock_decode
`default_nettype wire

// ==== spnf_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spnf_host_model (
	input  wire logic clk,
	output var logic sck,
	output var logic cs_n,
	output var logic mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// mode 0, sck rests low outside frames
	// pins move by nba on clk edges; all delays are whole clk periods, so no race
	task automatic xfer(input logic [7:0] c, a, d, input int n, output logic [7:0] q);
		logic [23:0] sh;
		sh = {c, a, d};
		q = 8'h00;
		@(posedge clk);
		cs_n <= 1'b0;
		#100;
		for (int i = 0; i < n * 8; i++) begin
			mosi <= sh[23 - i];
			#80 sck <= 1'b1;
			#80;
			// late sample: miso lags the fall by the sync delay
			if (i >= 16) q = {q[6:0], miso_oe ? miso : 1'bx};
			sck <= 1'b0;
		end
		#100 cs_n <= 1'b1;
		mosi <= ~mosi;
		#400;
	endtask
endmodule // spnf_host_model
`default_nettype wire

// ==== spnf_feature_regs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "spnf_consts.vh"
module spnf_regs_monitor (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       sck,
	input wire logic       cs_n,
	input wire logic       mosi,
	input wire logic       miso,
	input wire logic       miso_oe,
	input wire logic       array_req,
	input wire logic [1:0] array_kind,
	input wire logic [9:0] array_block,
	input wire logic       array_addr_bad,
	input wire logic       array_otp,
	input wire logic       array_grant,
	input wire logic       array_busy,
	input wire logic       array_done,
	input wire logic       array_fail,
	input wire logic [1:0] array_ecc,
	input wire logic       reset_cmd,
	input wire logic       ecc_enable,
	input wire logic [1:0] otp_mode,
	input wire logic       otp_access,
	input wire logic       hw_guard_pin_on
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_busy_refuse: assert property (
		(array_req && array_busy && array_kind != `SPNF_KIND_READ) |-> !array_grant)
		else $error("grant while busy");
	chk_bad_refuse: assert property (
		(array_req && array_addr_bad && array_kind != `SPNF_KIND_READ) |-> !array_grant)
		else $error("grant to bad address");
	chk_otp_gate: assert property ((array_grant && array_otp) |-> otp_access)
		else $error("otp grant without enable");
	chk_otp_mode: assert property (
		(array_grant && array_otp && array_kind == `SPNF_KIND_PROGRAM) |-> (otp_mode == 2'h1))
		else $error("otp program granted outside otp space state");
	chk_grant_cause: assert property (!array_req |-> !array_grant)
		else $error("grant without request");
	chk_reset_pulse: assert property (reset_cmd |=> !reset_cmd)
		else $error("reset pulse too long");
	// frame end is seen through the sync, so allow a few cycles
	chk_oe_idle: assert property (cs_n [*5] |-> !miso_oe)
		else $error("miso driven while deselected");
	chk_ecc_default: assert property ($fell(rst) |-> ecc_enable)
		else $error("ecc enable not set after reset");
	chk_guard_hold: assert property (cs_n [*8] |-> $stable(hw_guard_pin_on))
		else $error("guard setting changed outside a frame");
	cover property (array_grant && array_kind == `SPNF_KIND_PROGRAM);
	cover property (reset_cmd);
	cover property (miso_oe);
endmodule // spnf_regs_monitor
bind spnf_feature_regs spnf_regs_monitor u_mon (.clk, .rst, .sck, .cs_n, .mosi, .miso,
	.miso_oe, .array_req, .array_kind, .array_block, .array_addr_bad, .array_otp,
	.array_grant, .array_busy, .array_done, .array_fail, .array_ecc, .reset_cmd,
	.ecc_enable, .otp_mode, .otp_access, .hw_guard_pin_on);
`default_nettype wire

// ==== tb_spi_nand_feature_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "spnf_consts.vh"
module tb_spi_nand_feature_regs;
	logic clk, rst, sck, cs_n, mosi, miso, miso_oe, array_req, array_addr_bad, array_otp;
	logic array_grant, array_busy, array_done, array_fail, reset_cmd, ecc_enable;
	logic otp_access, hw_guard_pin_on, g;
	logic [1:0] array_kind, array_ecc, otp_mode;
	logic [9:0] array_block;
	logic [7:0] v;
	logic [18:0] tbl [8];
	int err_total, check_count, rc;
	localparam logic [1:0] kr = `SPNF_KIND_READ;
	localparam logic [1:0] kp = `SPNF_KIND_PROGRAM;
	localparam logic [1:0] ke = `SPNF_KIND_ERASE;
	spnf_feature_regs uut (.clk, .rst, .sck, .cs_n, .mosi, .miso, .miso_oe, .array_req,
		.array_kind, .array_block, .array_addr_bad, .array_otp, .array_grant, .array_busy,
		.array_done, .array_fail, .array_ecc, .reset_cmd, .ecc_enable, .otp_mode,
		.otp_access, .hw_guard_pin_on);
	spnf_host_model host (.clk, .sck, .cs_n, .mosi, .miso, .miso_oe);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (reset_cmd) rc <= rc + 1;
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		host.xfer(`SPNF_CMD_READ_REG, a, 8'h00, 3, d);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		host.xfer(`SPNF_CMD_WRITE_REG, a, d, 3, x);
	endtask
	task automatic cmd(input logic [7:0] c);
		logic [7:0] x;
		host.xfer(c, 8'h00, 8'h00, 1, x);
	endtask
	// engine finish: busy held until the done pulse
	task automatic fin(input logic f, input logic [1:0] e);
		repeat (3) @(posedge clk);
		array_done <= 1'b1; array_fail <= f; array_ecc <= e; array_busy <= 1'b0;
		@(posedge clk);
		array_done <= 1'b0; array_fail <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic op(input logic [1:0] k, input logic [9:0] b, input logic bad, o, f,
		input logic [1:0] e);
		@(posedge clk);
		array_req <= 1'b1; array_kind <= k; array_block <= b; array_addr_bad <= bad;
		array_otp <= o;
		#1 g = array_grant;
		@(posedge clk);
		array_req <= 1'b0; array_busy <= g;
		if (g) fin(f, e);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#1000000;
		err_total++;
		$display("[ERR] run expected done seen hung");
		wrap_up;
	end
	initial begin
		rst = 1'b1; array_req = 1'b0; array_kind = 2'h0; array_block = 10'h000; rc = 0;
		array_addr_bad = 1'b0; array_otp = 1'b0; array_busy = 1'b0; array_done = 1'b0;
		array_fail = 1'b0; array_ecc = 2'h0; err_total = 0; check_count = 0;
		tbl = '{{8'h08, 10'd1021, 1'b1}, {8'h08, 10'd1022, 1'b0}, {8'h0c, 10'd1, 1'b0},
			{8'h0c, 10'd2, 1'b1}, {8'h48, 10'd511, 1'b1}, {8'h48, 10'd512, 1'b0},
			{8'h50, 10'd0, 1'b0}, {8'h00, 10'd1023, 1'b1}};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		array_busy <= 1'b1;
		fin(1'b0, 2'h1);
		rd(8'ha0, v); chk("prot", 8'h7c, v);
		rd(8'hb0, v); chk("cfg", 8'h10, v);
		rd(8'hc0, v); chk("stat", 8'h10, v);
		@(posedge clk); array_busy <= 1'b1;
		rd(8'hc0, v); chk("busy", 8'h11, v);
		@(posedge clk); array_busy <= 1'b0;
		$display("test reset_status done");
		cmd(8'h06); rd(8'hc0, v); chk("latch_on", 8'h12, v);
		cmd(8'h04); rd(8'hc0, v); chk("latch_off", 8'h10, v);
		op(kp, 10'd5, 0, 0, 0, 0); chk("no_latch", 8'h00, g);
		cmd(8'h06);
		op(kp, 10'd5, 0, 0, 0, 0); chk("prog_locked", 8'h00, g);
		op(ke, 10'd5, 0, 0, 0, 0); chk("erase_locked", 8'h00, g);
		rd(8'hc0, v); chk("lock_flags", 8'h1e, v);
		$display("test latch_lock done");
		foreach (tbl[j]) begin
			wr(8'ha0, tbl[j][18:11]);
			op(ke, tbl[j][10:1], 0, 0, 0, 0); chk("region", {7'h00, tbl[j][0]}, g);
		end
		rd(8'hc0, v); chk("erase_clear", 8'h1a, v);
		@(posedge clk); array_busy <= 1'b1;
		op(kp, 10'd100, 0, 0, 0, 0); chk("busy_refuse", 8'h00, g);
		op(kp, 10'd100, 0, 0, 0, 0); rd(8'hc0, v); chk("prog_clear", 8'h12, v);
		op(kp, 10'd100, 1, 0, 0, 0); chk("bad_addr", 8'h00, g);
		op(ke, 10'd200, 0, 0, 1, 0);
		op(kr, 10'd7, 0, 0, 0, 2'h2);
		rd(8'hc0, v); chk("fail_ecc", 8'h2e, v);
		$display("test regions done");
		cmd(8'hff); @(posedge clk); chk("reset_pulse", 8'h01, rc[7:0]);
		rd(8'hc0, v); chk("reset_flags", 8'h00, v & 8'h0c);
		rd(8'ha0, v); chk("keep_prot", 8'h00, v);
		rd(8'h55, v); chk("unmapped", 8'h00, v);
		wr(8'hc0, 8'h0c); rd(8'hc0, v); chk("stat_ro", 8'h00, v & 8'h0c);
		$display("test reset_cmd done");
		cmd(8'h06); op(kp, 10'd3, 0, 1, 0, 0); chk("otp_off", 8'h00, g);
		wr(8'hb0, 8'h4f); rd(8'hb0, v); chk("cfg_bits", 8'h40, v);
		chk("ecc_en", 8'h00, ecc_enable);
		chk("otp_acc", 8'h01, otp_access);
		rd(8'hc0, v); chk("stat_no_ecc", 8'h02, v & 8'hcf);
		op(kp, 10'd3, 0, 1, 0, 0); chk("otp_on", 8'h01, g);
		wr(8'ha0, 8'h02); chk("hw_guard", 8'h01, hw_guard_pin_on);
		wr(8'ha0, 8'h81); wr(8'hb0, 8'h70); wr(8'ha0, 8'h7c);
		rd(8'ha0, v); chk("frozen", 8'h81, v);
		wr(8'hb0, 8'hd0); rd(8'hb0, v); chk("otp_lock", 8'hf0, v);
		chk("otp_mode", 8'h03, otp_mode);
		$display("test config done");
		@(posedge clk); rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		rd(8'ha0, v); chk("prot_power", 8'h7c, v);
		rd(8'hb0, v); chk("cfg_power", 8'h10, v);
		wr(8'ha0, 8'h08); rd(8'ha0, v); chk("unfrozen", 8'h08, v);
		$display("test power_cycle done");
		wrap_up;
	end
endmodule // tb_spi_nand_feature_regs
`default_nettype wire
